// *** include/gdcfg_pkg.sv ***
// gate driver configuration package: register offsets, field layouts, reset values, timings
// assumes a byte-wide register port inside the device, one clock, active-low async reset
// What this block does
// - dead time two bits, default 120 ns
// - watchdog enable bit five, resets off
// - watchdog timeout select 10 to 100 ms
// - drive strength three bits, resets strongest
// - amplifier output clamp bit, default off
// - second bridge monitor disables, reset zero
// - first bridge monitor disables, reset zero
// - chopping off time 25 to 200 us
// - regulation disable bit, reset zero
// - reference scaling 100 to 25 percent
// - sample and hold enable, reset off
// - shunt amplifier gain two bits
// - lock code blocks writes to the drive, monitor and chop registers until unlocked
// - watchdog expiry sets fault flag bit six
package gdcfg_pkg;
  localparam logic [7:0] ADDR_MAIN = 8'h02;
  localparam logic [7:0] ADDR_DRIVE_WD = 8'h03;
  localparam logic [7:0] ADDR_MON = 8'h04;
  localparam logic [7:0] ADDR_CHOP = 8'h05;
  localparam logic [7:0] ADDR_FAULT = 8'h00;
  localparam logic [7:0] RST_DRIVE_WD = 8'h07;
  localparam logic [7:0] RST_MON = 8'h70;
  localparam logic [7:0] RST_CHOP = 8'h00;
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  localparam int LOCK_LSB = 3;
  localparam int CLR_BIT = 0;
  localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 6;
  localparam int WATCHDOG_ENABLE_BIT = 5;
  localparam int WD_SEL_LSB = 3;
  localparam int FAULT_BIT = 7;
  localparam int CLK_HZ = 10_000_000;
  localparam int WD_MS_0 = 10;
  localparam int WD_MS_1 = 20;
  localparam int WD_MS_2 = 50;
  localparam int WD_MS_3 = 100;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  typedef struct packed {
    logic [1:0] dead_time_select;
    logic watchdog_enable;
    logic [1:0] watchdog_timeout_select;
    logic [2:0] gate_drive_strength;
  } gdcfg_drive_t;
  typedef struct packed {
    logic amp_output_clamp;
    logic [2:0] overcurrent_threshold;
    logic mon_off_high_b;
    logic mon_off_low_b;
    logic mon_off_high_a;
    logic mon_off_low_a;
  } gdcfg_mon_t;
  typedef struct packed {
    logic [1:0] chop_off_time;
    logic regulation_disable;
    logic [1:0] ref_scale;
    logic sample_hold_enable;
    logic [1:0] amp_gain;
  } gdcfg_chop_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gdcfg_req_t;
endpackage

// *** logic/gdcfg_regs.sv ***
// configuration register bank with lock, watchdog timer and watchdog fault flag
// assumes register requests are framed by the serial port on the same clock, one per cycle
module gdcfg_regs #(
  parameter int WD_SCALE = gdcfg_pkg::CYC_PER_MS
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire gdcfg_pkg::gdcfg_req_t REQ,
  input wire logic WD_KICK,
  output logic [7:0] RDATA,
  output gdcfg_pkg::gdcfg_drive_t DRIVE_CFG,
  output gdcfg_pkg::gdcfg_mon_t MON_CFG,
  output gdcfg_pkg::gdcfg_chop_t CHOP_CFG,
  output logic WD_FAULT,
  output logic LOCKED
);
  import gdcfg_pkg::*;

  // the longest timeout must still fit the 32-bit count
  if (WD_SCALE < 1 || WD_SCALE > 2147483647 / WD_MS_3) begin : g_bad_scale
    $error("WD_SCALE must lie between one and the 32-bit count limit");
  end

  logic [7:0] drv_q, drv_d, mon_q, mon_d, chp_q, chp_d, rdata_q, rdata_d;
  logic lock_q, lock_d, wdf_q, wdf_d;
  logic [31:0] wd_cnt_q, wd_cnt_d;
  logic [31:0] wd_limit;
  logic wr_ok, wd_expire, clr_req;
  // shortest selectable timeout, a floor under any expiry
  localparam logic [31:0] WD_MIN_CYC = 32'(WD_MS_0 * WD_SCALE);

  // timeout in cycles for the selected code
  function automatic logic [31:0] wd_cycles(input logic [1:0] sel);
    int ms;
    unique case (sel)
      2'h0: ms = WD_MS_0;
      2'h1: ms = WD_MS_1;
      2'h2: ms = WD_MS_2;
      default: ms = WD_MS_3;
    endcase
    return 32'(ms * WD_SCALE);
  endfunction

  assign wr_ok = REQ.wr && !lock_q;
  assign clr_req = REQ.wr && (REQ.addr == ADDR_MAIN) && REQ.wdata[CLR_BIT];
  assign wd_limit = wd_cycles(drv_q[WD_SEL_LSB +: 2]);
  assign wd_expire = drv_q[WATCHDOG_ENABLE_BIT] && (wd_cnt_q >= wd_limit - 32'h1);

  // register writes, lock handling; main register always writable so unlock works
  always_comb begin
    drv_d = drv_q;
    mon_d = mon_q;
    chp_d = chp_q;
    lock_d = lock_q;
    if (REQ.wr && REQ.addr == ADDR_MAIN) begin
      if (!lock_q && REQ.wdata[LOCK_LSB +: 3] == LOCK_CODE) lock_d = 1'b1;
      if (lock_q && REQ.wdata[LOCK_LSB +: 3] == UNLOCK_CODE) lock_d = 1'b0;
    end
    if (wr_ok && REQ.addr == ADDR_DRIVE_WD) drv_d = REQ.wdata;
    if (wr_ok && REQ.addr == ADDR_MON) mon_d = REQ.wdata;
    if (wr_ok && REQ.addr == ADDR_CHOP) chp_d = REQ.wdata;
  end

  // watchdog: counts while enabled, restarts on kick or disable; expiry beats a clear
  always_comb begin
    wd_cnt_d = wd_cnt_q + 32'h1;
    if (!drv_q[WATCHDOG_ENABLE_BIT] || WD_KICK || wd_expire) wd_cnt_d = 32'h0;
    wdf_d = wdf_q;
    if (clr_req) wdf_d = 1'b0;
    if (wd_expire) wdf_d = 1'b1;
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (REQ.rd) begin
      unique case (REQ.addr)
        ADDR_FAULT: rdata_d = {wdf_q, wdf_q, 6'h00};
        ADDR_MAIN: rdata_d = {2'h0, lock_q ? LOCK_CODE : UNLOCK_CODE, 3'h0};
        ADDR_DRIVE_WD: rdata_d = drv_q;
        ADDR_MON: rdata_d = mon_q;
        ADDR_CHOP: rdata_d = chp_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // configuration bytes and lock state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drv_q <= RST_DRIVE_WD;
      mon_q <= RST_MON;
      chp_q <= RST_CHOP;
      lock_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      mon_q <= mon_d;
      chp_q <= chp_d;
      lock_q <= lock_d;
    end
  end

  // watchdog count and its sticky flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdf_q <= 1'b0;
      wd_cnt_q <= 32'h0;
    end else begin
      wdf_q <= wdf_d;
      wd_cnt_q <= wd_cnt_d;
    end
  end

  // read data holds between reads
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from the registers, so a write acts the next cycle
  assign DRIVE_CFG = gdcfg_drive_t'(drv_q);
  assign MON_CFG = gdcfg_mon_t'(mon_q);
  assign CHOP_CFG = gdcfg_chop_t'(chp_q);
  assign WD_FAULT = wdf_q;
  assign LOCKED = lock_q;
  assign RDATA = rdata_q;

  // write path: locked bytes stay put, accepted bytes land one cycle later
  a_locked_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    lock_q && REQ.addr != ADDR_MAIN |=> $stable(drv_q) && $stable(mon_q) && $stable(chp_q))
    else $error("locked register changed");

  a_write_lands: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.wr && !lock_q && REQ.addr == ADDR_MON |=> MON_CFG == $past(REQ.wdata))
    else $error("accepted write not applied");

  a_chop_write: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.wr && !lock_q && REQ.addr == ADDR_CHOP |=> CHOP_CFG == $past(REQ.wdata))
    else $error("config write not applied");

  a_drive_write: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.wr && !lock_q && REQ.addr == ADDR_DRIVE_WD |=> DRIVE_CFG == $past(REQ.wdata))
    else $error("drive write not applied");

  // lock state moves only on its two codes
  a_lock_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    !lock_q && REQ.wr && REQ.addr == ADDR_MAIN && REQ.wdata[LOCK_LSB +: 3] == LOCK_CODE
    |=> LOCKED)
    else $error("lock code not taken");

  a_unlock: assert property (@(posedge CLK) disable iff (!RST_N)
    lock_q && REQ.wr && REQ.addr == ADDR_MAIN && REQ.wdata[LOCK_LSB +: 3] == UNLOCK_CODE
    |=> !LOCKED)
    else $error("unlock failed");

  a_lock_stays: assert property (@(posedge CLK) disable iff (!RST_N)
    lock_q && !(REQ.wr && REQ.addr == ADDR_MAIN && REQ.wdata[LOCK_LSB +: 3] == UNLOCK_CODE)
    |=> LOCKED)
    else $error("lock dropped without unlock code");

  a_open_stays: assert property (@(posedge CLK) disable iff (!RST_N)
    !lock_q && !(REQ.wr && REQ.addr == ADDR_MAIN && REQ.wdata[LOCK_LSB +: 3] == LOCK_CODE)
    |=> !LOCKED)
    else $error("lock taken without lock code");

  // read path: data shows one cycle after the request and then holds
  a_read_back: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.rd && REQ.addr == ADDR_CHOP |=> RDATA == $past(chp_q))
    else $error("readback mismatch");

  a_read_drive: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.rd && REQ.addr == ADDR_DRIVE_WD |=> RDATA == $past(drv_q))
    else $error("drive readback mismatch");

  a_read_mon: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.rd && REQ.addr == ADDR_MON |=> RDATA == $past(mon_q))
    else $error("monitor readback mismatch");

  a_read_fault: assert property (@(posedge CLK) disable iff (!RST_N)
    REQ.rd && REQ.addr == ADDR_FAULT |=> RDATA == {{2{$past(wdf_q)}}, 6'h00})
    else $error("fault readback mismatch");

  a_rdata_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !REQ.rd |=> $stable(RDATA))
    else $error("read data moved without a read");

  // watchdog: idles when off, restarts on a kick, never trips before the shortest timeout
  a_cnt_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    !drv_q[WATCHDOG_ENABLE_BIT] |=> wd_cnt_q == 32'h0 && !$rose(wdf_q))
    else $error("watchdog ran while disabled");

  a_kick_restart: assert property (@(posedge CLK) disable iff (!RST_N)
    WD_KICK |=> wd_cnt_q == 32'h0)
    else $error("kick did not restart the count");

  a_wd_no_early: assert property (@(posedge CLK) disable iff (!RST_N)
    wd_cnt_q < WD_MIN_CYC - 32'h1 |-> !wd_expire)
    else $error("watchdog expired before shortest timeout");

  a_wd_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    wd_expire |=> WD_FAULT)
    else $error("watchdog flag not set");

  a_fault_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    wdf_q && !clr_req |=> WD_FAULT)
    else $error("fault flag dropped without clear");

  a_fault_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    clr_req && !wd_expire |=> !WD_FAULT)
    else $error("fault clear ignored");

  // main scenarios worth seeing at least once
  c_lock: cover property (@(posedge CLK) disable iff (!RST_N) $rose(lock_q));
  c_wd: cover property (@(posedge CLK) disable iff (!RST_N) $rose(wdf_q));
  c_blocked: cover property (@(posedge CLK) disable iff (!RST_N) lock_q && REQ.wr);
  c_unlock: cover property (@(posedge CLK) disable iff (!RST_N) $fell(lock_q));
  c_clear: cover property (@(posedge CLK) disable iff (!RST_N) clr_req && wdf_q);
endmodule

// *** tb/gdcfg_tb.sv ***
// testbench for the configuration register bank: byte reads and writes, lock, watchdog
// assumes gdcfg_regs and gdcfg_pkg are compiled first; assertions live in the design files
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gdcfg_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic kick = 0;
  gdcfg_req_t req = '0;
  logic [7:0] rdata;
  gdcfg_drive_t drive_cfg;
  gdcfg_mon_t mon_cfg;
  gdcfg_chop_t chop_cfg;
  logic wd_fault;
  logic locked;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] v;
  // small scale keeps the 10 ms timeout at 40 cycles
  gdcfg_regs #(.WD_SCALE(4)) dut (.CLK(clk), .RST_N(rst_n), .REQ(req), .WD_KICK(kick),
    .RDATA(rdata), .DRIVE_CFG(drive_cfg), .MON_CFG(mon_cfg), .CHOP_CFG(chop_cfg),
    .WD_FAULT(wd_fault), .LOCKED(locked));
  always #50 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // tasks enter and leave 10 ns after a rising edge; an idle edge
  // between requests keeps back-to-back calls from colliding
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    #10 req = '0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #10 req = '0;
    cyc(1);
    chk(rdata, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  function automatic logic [7:0] cfg_of(input logic [7:0] a);
    case (a)
      ADDR_DRIVE_WD: return drive_cfg;
      ADDR_MON: return mon_cfg;
      default: return chop_cfg;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #(5000 * 100);
    miscompares++;
    report_and_stop();
  end
  initial begin
    cyc(16);
    rst_n = 1;
    rd(ADDR_DRIVE_WD, RST_DRIVE_WD);
    rd(ADDR_MON, RST_MON);
    rd(ADDR_CHOP, RST_CHOP);
    rd(ADDR_MAIN, {2'b00, UNLOCK_CODE, 3'b000});
    rd(8'h07, 8'h00);
    // v = {i[1:0], i, i} walks every code of every field
    for (int i = 0; i < 8; i++) begin
      for (int a = 3; a < 6; a++) begin
        v = 8'(i * 8'h49);
        wr(8'(a), v);
        chk(cfg_of(8'(a)), v);
        rd(8'(a), v);
      end
    end
    // the walk left the watchdog running; stopping it zeroes the count
    wr(ADDR_DRIVE_WD, RST_DRIVE_WD);
    // locked writes to the monitor and config registers must vanish
    wr(ADDR_MAIN, {2'b00, LOCK_CODE, 3'b000});
    chk({7'h0, locked}, 8'h01);
    wr(ADDR_MON, 8'h0f);
    rd(ADDR_MON, 8'hff);
    wr(ADDR_CHOP, 8'h0f);
    rd(ADDR_CHOP, 8'hff);
    rd(ADDR_MAIN, 8'h30);
    wr(ADDR_MAIN, {2'b00, UNLOCK_CODE, 3'b000});
    chk({7'h0, locked}, 8'h00);
    rd(ADDR_MAIN, 8'h18);
    wr(ADDR_MON, 8'h0f);
    rd(ADDR_MON, 8'h0f);
    // watchdog at 10 ms: a kick restarts the 40-cycle count
    wr(ADDR_DRIVE_WD, 8'h27);
    cyc(30);
    kick = 1;
    cyc(1);
    kick = 0;
    cyc(30);
    chk({7'h0, wd_fault}, 8'h00);
    cyc(20);
    chk({7'h0, wd_fault}, 8'h01);
    rd(ADDR_FAULT, 8'hc0);
    wr(ADDR_DRIVE_WD, 8'h07);
    wr(ADDR_MAIN, 8'h01);
    chk({7'h0, wd_fault}, 8'h00);
    rd(ADDR_FAULT, 8'h00);
    report_and_stop();
  end
endmodule
